// *** dtp_defines.svh ***
`ifndef DTP_DEFINES_SVH
`define DTP_DEFINES_SVH
// register indices (object numbers)
`define DTP_OFS_FUNC 16'h60b8
`define DTP_OFS_STAT 16'h60b9
`define DTP_OFS_P1_RISE 16'h60ba
`define DTP_OFS_P1_FALL 16'h60bb
`define DTP_OFS_P2_RISE 16'h60bc
`define DTP_OFS_P2_FALL 16'h60bd
// function word fields, channel one base 0, channel two base 8
`define DTP_CH2_BASE 8
`define DTP_BIT_EN 0
`define DTP_BIT_CONT 1
`define DTP_BIT_SRC 2
`define DTP_BIT_RISE 4
`define DTP_BIT_FALL 5
`define DTP_FUNC_MASK 16'h3737
`define DTP_FUNC_RST 16'h0000
// status fields per channel
`define DTP_ST_ON 0
`define DTP_ST_RISE 2
`define DTP_ST_FALL 1
`define DTP_POS_RST 32'h0000_0000
`endif

// *** dtp_pkg.sv ***
package dtp_pkg;
  typedef logic [15:0] dtp_word_t;
  typedef logic signed [31:0] dtp_pos_t;
  typedef enum logic [1:0] {
    DTP_IDLE = 2'b00,
    DTP_ARMED = 2'b01,
    DTP_DONE = 2'b11
  } dtp_state_e;
endpackage : dtp_pkg

// *** dtp_chan_if.sv ***
`timescale 1ns/1ps
interface dtp_chan_if;
  logic enable;
  logic continuous;
  logic use_zero;
  logic rise_en;
  logic fall_en;
  logic run;
  logic rise_stored;
  logic fall_stored;
  logic signed [31:0] rise_pos;
  logic signed [31:0] fall_pos;
  modport ctrl (output enable, continuous, use_zero, rise_en, fall_en,
                input run, rise_stored, fall_stored, rise_pos, fall_pos);
  modport chan (input enable, continuous, use_zero, rise_en, fall_en,
                output run, rise_stored, fall_stored, rise_pos, fall_pos);
endinterface : dtp_chan_if

// *** dtp_channel.sv ***
`timescale 1ns/1ps
`include "dtp_defines.svh"
module dtp_channel (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_probe_sync,
  input wire logic i_zero_sync,
  input wire logic i_inhibit,
  input wire logic signed [31:0] i_position,
  dtp_chan_if.chan ch
);
  import dtp_pkg::*;
  dtp_state_e state_q, state_d;
  logic trig_q, trig_d;
  logic rise_st_q, rise_st_d, fall_st_q, fall_st_d;
  dtp_pos_t rise_q, rise_d, fall_q, fall_d;
  logic trig, rise_ev, fall_ev, active;

  // ****************
  // capture
  // ****************
  always_comb begin
    trig = ch.use_zero ? i_zero_sync : i_probe_sync;
    active = ch.enable && !i_inhibit;
    rise_ev = !trig_q && trig && ch.rise_en;
    fall_ev = trig_q && !trig && ch.fall_en;
    trig_d = trig;
    state_d = state_q;
    rise_st_d = rise_st_q;
    fall_st_d = fall_st_q;
    rise_d = rise_q;
    fall_d = fall_q;
    case (state_q)
      DTP_IDLE: begin
        if (active) begin
          state_d = DTP_ARMED;
          rise_st_d = 1'b0;
          fall_st_d = 1'b0;
        end else begin
          rise_st_d = 1'b0;
          fall_st_d = 1'b0;
        end
      end
      DTP_ARMED: begin
        if (!active) begin
          state_d = DTP_IDLE;
        end else if (rise_ev || fall_ev) begin
          if (rise_ev) begin
            rise_d = i_position;
            rise_st_d = 1'b1;
          end
          if (fall_ev) begin
            fall_d = i_position;
            fall_st_d = 1'b1;
          end
          if (!ch.continuous) begin
            state_d = DTP_DONE;
          end
        end
      end
      default: begin
        if (!ch.enable) begin
          state_d = DTP_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      state_q <= DTP_IDLE;
      trig_q <= 1'b0;
      rise_st_q <= 1'b0;
      fall_st_q <= 1'b0;
      rise_q <= `DTP_POS_RST;
      fall_q <= `DTP_POS_RST;
    end else begin
      state_q <= state_d;
      trig_q <= trig_d;
      rise_st_q <= rise_st_d;
      fall_st_q <= fall_st_d;
      rise_q <= rise_d;
      fall_q <= fall_d;
    end
  end

  assign ch.run = (state_q != DTP_IDLE);
  assign ch.rise_stored = rise_st_q;
  assign ch.fall_stored = fall_st_q;
  assign ch.rise_pos = rise_q;
  assign ch.fall_pos = fall_q;
endmodule : dtp_channel

// *** dtp_touch_probe.sv ***
`timescale 1ns/1ps
`include "dtp_defines.svh"
// Summary of operation
// - bit 0 enables channel one
// - bit 1 single-shot or continuous, channel one
// - bit 2 picks probe input or zero pulse
// - bit 4 enables rising capture, channel one
// - bit 5 enables falling capture, channel one
// - bits 8, 9 enable and mode, channel two
// - bits 10,12,13 source and edges, channel two
// - channel one captures in two signed words
// - channel two captures in two signed words
// - no capture during init state or homing mode
// - edges are logical inactive/active transitions
// - zero pulse at single-turn position zero
// - status bit 0 shows channel one running
// - status bit 2 shows rising value stored
module dtp_touch_probe (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_probe_input_one,
  input wire logic i_probe_input_two,
  input wire logic i_zero_pulse,
  input wire logic i_comm_init,
  input wire logic i_homing_operating_mode,
  input wire logic signed [31:0] i_position,
  input wire logic i_wr,
  input wire logic [15:0] i_index,
  input wire logic [31:0] i_wdata,
  output logic [31:0] o_rdata,
  output logic o_rvalid
);
  import dtp_pkg::*;

  // ****************
  // input synchronisers
  // ****************
  logic [2:0] s1_q, s2_q;
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      s1_q <= 3'h0;
      s2_q <= 3'h0;
    end else begin
      s1_q <= {i_zero_pulse, i_probe_input_two, i_probe_input_one};
      s2_q <= s1_q;
    end
  end

  // ****************
  // function word
  // ****************
  dtp_word_t func_q, func_d;
  logic inhibit;
  always_comb begin
    func_d = func_q;
    if (i_wr && i_index == `DTP_OFS_FUNC) begin
      func_d = i_wdata[15:0] & `DTP_FUNC_MASK;
    end
  end
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      func_q <= `DTP_FUNC_RST;
    end else begin
      func_q <= func_d;
    end
  end
  assign inhibit = i_comm_init || i_homing_operating_mode;

  // ****************
  // channels
  // ****************
  dtp_chan_if c1 ();
  dtp_chan_if c2 ();
  assign c1.enable = func_q[`DTP_BIT_EN];
  assign c1.continuous = func_q[`DTP_BIT_CONT];
  assign c1.use_zero = func_q[`DTP_BIT_SRC];
  assign c1.rise_en = func_q[`DTP_BIT_RISE];
  assign c1.fall_en = func_q[`DTP_BIT_FALL];
  assign c2.enable = func_q[`DTP_CH2_BASE + `DTP_BIT_EN];
  assign c2.continuous = func_q[`DTP_CH2_BASE + `DTP_BIT_CONT];
  assign c2.use_zero = func_q[`DTP_CH2_BASE + `DTP_BIT_SRC];
  assign c2.rise_en = func_q[`DTP_CH2_BASE + `DTP_BIT_RISE];
  assign c2.fall_en = func_q[`DTP_CH2_BASE + `DTP_BIT_FALL];

  dtp_channel u_ch1 (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_probe_sync(s2_q[0]),
    .i_zero_sync(s2_q[2]),
    .i_inhibit(inhibit),
    .i_position(i_position),
    .ch(c1)
  );
  dtp_channel u_ch2 (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_probe_sync(s2_q[1]),
    .i_zero_sync(s2_q[2]),
    .i_inhibit(inhibit),
    .i_position(i_position),
    .ch(c2)
  );

  // ****************
  // status and read port
  // ****************
  dtp_word_t status;
  logic [31:0] rdata_d;
  always_comb begin
    status = 16'h0000;
    status[`DTP_ST_ON] = c1.run;
    status[`DTP_ST_RISE] = c1.rise_stored;
    status[`DTP_ST_FALL] = c1.fall_stored;
    status[`DTP_CH2_BASE + `DTP_ST_ON] = c2.run;
    status[`DTP_CH2_BASE + `DTP_ST_RISE] = c2.rise_stored;
    status[`DTP_CH2_BASE + `DTP_ST_FALL] = c2.fall_stored;
    rdata_d = 32'h0000_0000;
    if (i_index == `DTP_OFS_FUNC) begin
      rdata_d = {16'h0000, func_q};
    end else if (i_index == `DTP_OFS_STAT) begin
      rdata_d = {16'h0000, status};
    end else if (i_index == `DTP_OFS_P1_RISE) begin
      rdata_d = c1.rise_pos;
    end else if (i_index == `DTP_OFS_P1_FALL) begin
      rdata_d = c1.fall_pos;
    end else if (i_index == `DTP_OFS_P2_RISE) begin
      rdata_d = c2.rise_pos;
    end else if (i_index == `DTP_OFS_P2_FALL) begin
      rdata_d = c2.fall_pos;
    end
  end
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= 32'h0000_0000;
      o_rvalid <= 1'b0;
    end else begin
      o_rdata <= rdata_d;
      o_rvalid <= !i_wr;
    end
  end
endmodule : dtp_touch_probe

// *** dtp_sensor_model.sv ***
`timescale 1ns/1ps
// ****
// trigger sensors
// ****
module dtp_sensor_model #(
  parameter int MIN_PH = 4
) (
  input wire logic i_clock,
  input wire logic [2:0] i_lvl,
  output logic [2:0] o_pin
);
  int cnt [3];
  initial o_pin = 3'h0;
  always @(negedge i_clock) begin
    for (int k = 0; k < 3; k++) begin
      cnt[k] <= cnt[k] + 1;
      if (i_lvl[k] != o_pin[k] && cnt[k] >= MIN_PH) begin
        o_pin[k] <= i_lvl[k];
        cnt[k] <= 0;
      end
    end
  end
endmodule : dtp_sensor_model

// *** dtp_touch_probe_assertions.sv ***
`timescale 1ns/1ps
// ****
// checker
// ****
module dtp_checker (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_probe_input_one,
  input wire logic i_zero_pulse,
  input wire logic i_comm_init,
  input wire logic i_homing_operating_mode,
  input wire logic i_wr,
  input wire logic [15:0] i_index,
  input wire logic [31:0] i_wdata,
  input wire logic [31:0] o_rdata
);
  logic [15:0] fn_q;
  logic [15:0] fn_d;
  wire logic rs = !i_wr && i_index == 16'h60b9;
  wire logic fw = i_wr && i_index == 16'h60b8;
  wire logic q1 = !i_probe_input_one && !i_zero_pulse;
  always_comb fn_d = fw ? i_wdata[15:0] & 16'h3737 : fn_q;
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) fn_q <= 16'h0;
    else fn_q <= fn_d;
  end
  default clocking dcb @(posedge i_clock); endclocking
  default disable iff (i_rst);
  fn_mask_a: assert property (fw ##1 (!i_wr && i_index == 16'h60b8) |=>
    o_rdata == ($past(i_wdata, 2) & 32'h3737)) else $error("func readback");
  rsv_zero_a: assert property (!i_wr && i_index == 16'h60b8 |=>
    (o_rdata & 32'hffffc8c8) == 32'h0) else $error("reserved bits set");
  init_off_a: assert property ((rs && i_comm_init)[*4] |=> !o_rdata[0])
    else $error("run during init");
  home_off_a: assert property ((rs && i_homing_operating_mode)[*4] |=> !o_rdata[8])
    else $error("run during homing");
  run_off_a: assert property ((rs && !fn_q[0])[*3] |=> !o_rdata[0])
    else $error("run while off");
  run2_off_a: assert property ((rs && !fn_q[8])[*3] |=> !o_rdata[8])
    else $error("run two while off");
  hold_val_a: assert property ((!i_wr && i_index == 16'h60ba && !fn_q[0])[*4] |=>
    $stable(o_rdata)) else $error("capture while off");
  fresh_a: assert property (($rose(fn_q[0]) && q1) ##1 (rs && q1)[*4] |=>
    !o_rdata[2]) else $error("stale stored flag");
endmodule : dtp_checker
bind dtp_touch_probe dtp_checker dtp_checker_inst (.i_clock(i_clock), .i_rst(i_rst),
  .i_probe_input_one(i_probe_input_one), .i_zero_pulse(i_zero_pulse),
  .i_comm_init(i_comm_init), .i_homing_operating_mode(i_homing_operating_mode),
  .i_wr(i_wr), .i_index(i_index), .i_wdata(i_wdata), .o_rdata(o_rdata));

// *** tb_top.sv ***
`timescale 1ns/1ps
// ****
// bench
// ****
module tb_top;
  import dtp_pkg::*;
  logic i_clock = 1'h0;
  logic i_rst = 1'h1;
  logic [1:0] inh = 2'h0;
  dtp_pos_t pos = '0;
  logic i_wr = 1'h0;
  dtp_word_t idx = '0;
  logic [31:0] wd = '0;
  logic [31:0] o_rdata;
  logic o_rvalid;
  logic [2:0] lvl = 3'h0;
  logic [2:0] pin;
  int err_total = 0;
  int n_checks = 0;
  int cyc = 0;
  int fn = 0;
  int cap [4] = '{0, 0, 0, 0};
  int st [2];
  int done [2];
  logic [15:0] r = 16'h1f;
  logic [15:0] cfg [8] = '{16'h0011, 16'h0023, 16'h0015, 16'h0017,
    16'h1100, 16'h2300, 16'h1500, 16'h2313};
  always #50 i_clock = ~i_clock;
  dtp_touch_probe dtp_touch_probe_inst (.i_clock(i_clock), .i_rst(i_rst),
    .i_probe_input_one(pin[0]), .i_probe_input_two(pin[1]), .i_zero_pulse(pin[2]),
    .i_comm_init(inh[0]), .i_homing_operating_mode(inh[1]), .i_position(pos),
    .i_wr(i_wr), .i_index(idx), .i_wdata(wd), .o_rdata(o_rdata), .o_rvalid(o_rvalid));
  dtp_sensor_model #(.MIN_PH(4)) dtp_sensor_model_inst (.i_clock(i_clock), .i_lvl(lvl),
    .o_pin(pin));
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t read %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(negedge i_clock);
    i_wr = 1'h1;
    idx = a;
    wd = d;
    @(negedge i_clock);
    i_wr = 1'h0;
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [31:0] e, input logic [31:0] m);
    idx = a;
    repeat (5) @(posedge i_clock);
    @(negedge i_clock);
    chk({o_rvalid, o_rdata & m}, {1'h1, e});
  endtask : rd
  function automatic logic [31:0] stat();
    return {23'h0, fn[8] & !inh, 5'h0, st[0] != 0, 1'h0, fn[0] & !inh};
  endfunction : stat
  task automatic pulse(input int p);
    r = {r[14:0], r[15] ^ r[13] ^ r[12] ^ r[10]};
    pos = {r, ~r};
    for (int e = 1; e >= 0; e--) begin
      lvl[p] = e[0];
      repeat (10) @(negedge i_clock);
      for (int c = 0; c < 2; c++)
        if (fn[8*c] && !inh && (fn[8*c+2] ? p == 2 : p == c) && fn[8*c+5-e] && !done[c]) begin
          cap[2*c+1-e] = pos;
          st[c] |= e;
          done[c] = !fn[8*c+1];
        end
    end
  endtask : pulse
  always @(posedge i_clock) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      end_sim();
    end
  end
  initial begin
    repeat (8) @(posedge i_clock);
    @(negedge i_clock);
    i_rst = 1'h0;
    rd(16'h60b9, 32'h0, '1);
    for (int k = 0; k < 9; k++) begin
      wr(16'h60b8, 32'h0);
      fn = 0;
      rd(16'h60b9, 32'h0, 32'h105);
      r = {r[14:0], r[15] ^ r[13] ^ r[12] ^ r[10]};
      fn = k < 8 ? cfg[k] : 16'h1313;
      wr(16'h60b8, {r, 16'(fn) | (r & 16'hc8c8)});
      st = '{0, 0};
      done = '{0, 0};
      inh = k < 8 ? 2'h0 : 2'h1 << (r[0]);
      rd(16'h60b9, stat(), 32'h105);
      rd(16'h60b8, 32'(fn), '1);
      for (int p = 0; p < 6; p++) pulse(p % 3);
      for (int j = 0; j < 4; j++) rd(16'(16'h60ba + j), cap[j], '1);
      rd(16'h60b9, stat(), 32'h105);
      $display("test %0d done", k);
    end
    inh = 2'h0;
    wr(16'h60ba, {r, r});
    rd(16'h60ba, cap[0], '1);
    rd(16'h60be, 32'h0, '1);
    wr(16'h60b8, {r, r});
    rd(16'h60b8, {16'h0, r & 16'h3737}, '1);
    end_sim();
  end
endmodule : tb_top
